// ==== svpl_map.vh ====
/*
 svpl_map.vh: offsets, field positions, reset values and timing counts
 of the servo position loop. Assumes a 10 MHz pclk and a 32-bit APB.
*/
`ifndef SVPL_MAP_VH
`define SVPL_MAP_VH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SVPL_CLK_HZ 10000000
`define SVPL_BAUD 38400
`define SVPL_BAUD_DIV (`SVPL_CLK_HZ / `SVPL_BAUD)
`define SVPL_MS_DIV (`SVPL_CLK_HZ / 1000)
`define SVPL_LOOP_HZ 10000
`define SVPL_LOOP_DIV (`SVPL_CLK_HZ / `SVPL_LOOP_HZ)
`define SVPL_PID_SHIFT 8
`define SVPL_PROF_K 64'h0000000003938700
`define SVPL_V_SCALE 64'h0000000000000fa0
`define SVPL_A_SCALE 64'h00000000000000f0
`define SVPL_TR_DEPTH 64
// ---------------------------------------------------------------
// parameter words, byte offset = 4 * index
// ---------------------------------------------------------------
`define SVPL_NPAR 15
`define SVPL_I_CTRL 4'h0
`define SVPL_I_GTOP 4'h1
`define SVPL_I_GBOT 4'h2
`define SVPL_I_KP 4'h3
`define SVPL_I_KI 4'h4
`define SVPL_I_KD 4'h5
`define SVPL_I_FELIM 4'h6
`define SVPL_I_LINES 4'h7
`define SVPL_I_VTOP 4'h8
`define SVPL_I_ACCEL 4'h9
`define SVPL_I_LEN 4'ha
`define SVPL_I_GAP 4'hb
`define SVPL_I_REP 4'hc
`define SVPL_I_TRTIME 4'hd
`define SVPL_I_TRSEL 4'he
// ---------------------------------------------------------------
// other registers
// ---------------------------------------------------------------
`define SVPL_A_STATUS 8'h40
`define SVPL_A_CMDPOS 8'h44
`define SVPL_A_ENCPOS 8'h48
`define SVPL_A_PERR 8'h4c
`define SVPL_A_TORQUE 8'h50
`define SVPL_A_TRIDX 8'h54
`define SVPL_A_TRDATA 8'h58
// ---------------------------------------------------------------
// control bits
// ---------------------------------------------------------------
`define SVPL_B_EDGE 0
`define SVPL_B_CWCCW 1
`define SVPL_B_REV 2
`define SVPL_B_START 3
`define SVPL_B_SAVE 4
`define SVPL_B_CLRFE 5
`define SVPL_B_TRACE 6
// ---------------------------------------------------------------
// reset values and host command bytes
// ---------------------------------------------------------------
`define SVPL_R_GEAR 32'h00000001
`define SVPL_R_KP 32'h00000100
`define SVPL_R_KD 32'h00000040
`define SVPL_R_FELIM 32'h00001000
`define SVPL_R_LINES 32'h000001f4
`define SVPL_R_VTOP 32'h00000064
`define SVPL_R_ACCEL 32'h0000000a
`define SVPL_R_LEN 32'h00000fa0
`define SVPL_R_GAP 32'h00000064
`define SVPL_R_REP 32'h00000001
`define SVPL_R_TRTIME 32'h00000040
`define SVPL_C_SAVE 8'h53
`define SVPL_C_READ 8'h52
`define SVPL_C_TOGGLE 8'h54
`endif

// ==== svpl_top.v ====
/*
 svpl_top.v: position loop of a brushed servo drive: step/direction input
 with gear, x4 encoder, PID, following-error trip, self-test profiler,
 trace capture, serial host link and parameter save port.
 Assumes inputs synchronous to pclk and a current loop fed by torque_set.
*/
// Decided for this implementation: the APB register port and the register addresses.
// How it works
// - gear top and bottom programmable 1 to 255
// - following error is command minus encoder, continuous
// - error magnitude at limit trips protection, flags
// - encoder decoded at four counts per line
// - line count only feeds the self-test profiler
// - step counted on selected rising or falling edge
// - cw/ccw mode ignores the level of idle input
// - direction invert reverses sense for same level
// - output has gain times present error
// - output adds gain times summed error
// - output adds gain times error change
// - controller output is the torque set point
// - self-test trapezoid peaks at programmed speed, rpm
// - self-test ramps at programmed acceleration
// - each self-test move travels programmed counts
// - forward, wait, reverse, wait, repeated as programmed
// - single start/stop command acts at once
// - serial link runs at 38400 baud
// - save command writes parameters to storage
// - read command returns parameters over serial
// - trace command, feedback, error of i, v, p
// - trace runs over programmed trace time window
`include "svpl_map.vh"
`default_nettype none
module svpl_top (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // step command
   input wire step_in,
   input wire dir_in,
   // encoder
   input wire enc_a,
   input wire enc_b,
   // current loop
   input wire signed [31:0] i_meas,
   output reg signed [31:0] torque_set,
   output reg fe_protect,
   // serial host link
   input wire uart_rxd,
   output reg uart_txd,
   // parameter storage
   output reg nv_wr,
   output reg [3:0] nv_addr,
   output reg [31:0] nv_data
);
// ---------------------------------------------------------------
// functions
// ---------------------------------------------------------------
function is_par;
   input [7:0] a;
   begin
      is_par = (a[7:6] == 2'h0) && (a[5:2] != 4'hf) && (a[1:0] == 2'h0);
   end
endfunction
function edge_hit;
   input now, old, fall;
   begin
      edge_hit = fall ? (old & ~now) : (~old & now);
   end
endfunction
function [31:0] rval;
   input [3:0] i;
   begin
      case (i)
         `SVPL_I_GTOP, `SVPL_I_GBOT: rval = `SVPL_R_GEAR;
         `SVPL_I_KP: rval = `SVPL_R_KP;
         `SVPL_I_KD: rval = `SVPL_R_KD;
         `SVPL_I_FELIM: rval = `SVPL_R_FELIM;
         `SVPL_I_LINES: rval = `SVPL_R_LINES;
         `SVPL_I_VTOP: rval = `SVPL_R_VTOP;
         `SVPL_I_ACCEL: rval = `SVPL_R_ACCEL;
         `SVPL_I_LEN: rval = `SVPL_R_LEN;
         `SVPL_I_GAP: rval = `SVPL_R_GAP;
         `SVPL_I_REP: rval = `SVPL_R_REP;
         `SVPL_I_TRTIME: rval = `SVPL_R_TRTIME;
         default: rval = 32'h0;
      endcase
   end
endfunction
function [31:0] wval;
   input [3:0] i;
   input [31:0] d;
   begin
      if (i == `SVPL_I_CTRL)
         wval = {29'h0, d[2:0]};
      else if (i == `SVPL_I_GTOP || i == `SVPL_I_GBOT)
         wval = (d[7:0] == 8'h0) ? 32'h1 : {24'h0, d[7:0]};
      else
         wval = d;
   end
endfunction
// ---------------------------------------------------------------
// parameters, apb
// ---------------------------------------------------------------
reg [31:0] prm [0:14];
reg [5:0] tr_idx;
reg [31:0] rd_mux;
integer k;
wire apb_wr = psel & penable & pwrite & pready & ~pslverr;
wire ctrl_wr = apb_wr && paddr == 8'h0;
wire [31:0] ctrl = prm[0];
reg rx_done;
reg [7:0] rx_byte;
wire rx_cmd_s = rx_done && rx_byte == `SVPL_C_SAVE;
wire rx_cmd_r = rx_done && rx_byte == `SVPL_C_READ;
wire rx_cmd_t = rx_done && rx_byte == `SVPL_C_TOGGLE;
wire st_toggle = (ctrl_wr & pwdata[`SVPL_B_START]) | rx_cmd_t;
wire save_go = (ctrl_wr & pwdata[`SVPL_B_SAVE]) | rx_cmd_s;
wire clr_fe = ctrl_wr & pwdata[`SVPL_B_CLRFE];
wire trace_go = ctrl_wr & pwdata[`SVPL_B_TRACE];
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      for (k = 0; k < `SVPL_NPAR; k = k + 1) begin
         prm[k] <= rval(k[3:0]);
      end
   end else if (apb_wr && is_par(paddr)) begin
      prm[paddr[5:2]] <= wval(paddr[5:2], pwdata);
   end
end
// ---------------------------------------------------------------
// position and error
// ---------------------------------------------------------------
reg step_d, dir_d;
reg [1:0] ab_d;
reg signed [15:0] gfrac;
reg signed [31:0] cmd_pos, enc_pos, integ, err_prev;
reg st_step, st_rev;
wire fall = ctrl[`SVPL_B_EDGE];
wire cwccw = ctrl[`SVPL_B_CWCCW];
wire e_step = edge_hit(step_in, step_d, fall);
wire e_dir = edge_hit(dir_in, dir_d, fall);
// only edges count in cw/ccw mode, so the idle pin level is irrelevant
wire step_ev = cwccw ? (e_step ^ e_dir) : e_step;
wire fwd = (cwccw ? e_step : dir_in) ^ ctrl[`SVPL_B_REV];
wire signed [15:0] gnum = {8'h0, prm[1][7:0]};
wire signed [15:0] gden = {8'h0, prm[2][7:0]};
wire signed [15:0] gadd = !step_ev ? 16'sh0 : (fwd ? gnum : -gnum);
wire signed [15:0] gnext = gfrac + gadd;
wire gup = gnext >= gden;
wire gdn = gnext <= -gden;
wire signed [31:0] gd = gup ? 32'sh1 : (gdn ? 32'shffffffff : 32'sh0);
wire signed [31:0] sd = !st_step ? 32'sh0 : (st_rev ? 32'shffffffff : 32'sh1);
wire [3:0] q = {ab_d, enc_a, enc_b};
wire e_up = q == 4'h2 || q == 4'hb || q == 4'hd || q == 4'h4;
wire e_dn = q == 4'h1 || q == 4'h7 || q == 4'he || q == 4'h8;
wire signed [31:0] perr = cmd_pos - enc_pos;
wire [31:0] abs_err = perr[31] ? (~perr + 32'h1) : perr;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      step_d <= 1'b0;
      dir_d <= 1'b0;
      ab_d <= 2'h0;
      gfrac <= 16'sh0;
      cmd_pos <= 32'sh0;
      enc_pos <= 32'sh0;
      fe_protect <= 1'b0;
   end else begin
      step_d <= step_in;
      dir_d <= dir_in;
      ab_d <= {enc_a, enc_b};
      // one output count per clock drains the gear remainder
      if (gup)
         gfrac <= gnext - gden;
      else if (gdn)
         gfrac <= gnext + gden;
      else
         gfrac <= gnext;
      cmd_pos <= cmd_pos + gd + sd;
      if (e_up)
         enc_pos <= enc_pos + 32'sh1;
      else if (e_dn)
         enc_pos <= enc_pos - 32'sh1;
      if (abs_err >= prm[6])
         fe_protect <= 1'b1;
      else if (clr_fe)
         fe_protect <= 1'b0;
   end
end
// ---------------------------------------------------------------
// pid
// ---------------------------------------------------------------
reg [9:0] lp_cnt;
reg [13:0] ms_cnt;
wire lp_tick = lp_cnt == `SVPL_LOOP_DIV - 1;
wire ms_tick = ms_cnt == `SVPL_MS_DIV - 1;
wire signed [31:0] derr = perr - err_prev;
wire signed [49:0] pid = $signed({1'b0, prm[3][15:0]}) * perr
   + $signed({1'b0, prm[4][15:0]}) * integ
   + $signed({1'b0, prm[5][15:0]}) * derr;
wire signed [49:0] pid_sh = pid >>> `SVPL_PID_SHIFT;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      lp_cnt <= 10'h0;
      ms_cnt <= 14'h0;
      integ <= 32'sh0;
      err_prev <= 32'sh0;
      torque_set <= 32'sh0;
   end else begin
      lp_cnt <= lp_tick ? 10'h0 : lp_cnt + 10'h1;
      ms_cnt <= ms_tick ? 14'h0 : ms_cnt + 14'h1;
      if (fe_protect) begin
         integ <= 32'sh0;
         torque_set <= 32'sh0;
      end else if (lp_tick) begin
         integ <= integ + perr;
         err_prev <= perr;
         torque_set <= pid_sh[31:0];
      end
   end
end
// ---------------------------------------------------------------
// self-test profiler
// ---------------------------------------------------------------
localparam S_IDLE = 5'b00001;
localparam S_FWD = 5'b00010;
localparam S_GAP1 = 5'b00100;
localparam S_REV = 5'b01000;
localparam S_GAP2 = 5'b10000;
reg [4:0] st;
reg [63:0] vel, pacc;
reg [31:0] remain, adist, gap_cnt, rep_cnt;
// speed kept as counts/s * 60000; lines only scale the profile
wire [63:0] vmaxs = {48'h0, prm[8][15:0]} * {48'h0, prm[7][15:0]}
   * `SVPL_V_SCALE;
wire [63:0] astep = {48'h0, prm[9][15:0]} * {48'h0, prm[7][15:0]}
   * `SVPL_A_SCALE;
wire moving = st == S_FWD || st == S_REV;
wire decel = remain <= adist;
wire emit = moving && !ms_tick && pacc >= `SVPL_PROF_K && remain != 32'h0;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      st <= S_IDLE;
      vel <= 64'h0;
      pacc <= 64'h0;
      remain <= 32'h0;
      adist <= 32'h0;
      gap_cnt <= 32'h0;
      rep_cnt <= 32'h0;
      st_step <= 1'b0;
      st_rev <= 1'b0;
   end else begin
      st_step <= emit;
      st_rev <= st == S_REV;
      if (emit) begin
         pacc <= pacc - `SVPL_PROF_K;
         remain <= remain - 32'h1;
         if (!decel && vel < vmaxs)
            adist <= adist + 32'h1;
      end else if (moving && ms_tick) begin
         pacc <= pacc + vel;
         if (decel)
            vel <= (vel > astep + astep) ? vel - astep : astep;
         else
            vel <= (vel + astep >= vmaxs) ? vmaxs : vel + astep;
      end
      if (!moving) begin
         vel <= 64'h0;
         pacc <= 64'h0;
         adist <= 32'h0;
         remain <= prm[10];
      end
      if (st_toggle && st != S_IDLE) begin
         st <= S_IDLE;
      end else begin
         case (st)
            S_IDLE: begin
               rep_cnt <= 32'h0;
               if (st_toggle)
                  st <= S_FWD;
            end
            S_FWD: begin
               gap_cnt <= prm[11];
               if (remain == 32'h0)
                  st <= S_GAP1;
            end
            S_GAP1: begin
               if (gap_cnt == 32'h0)
                  st <= S_REV;
               else if (ms_tick)
                  gap_cnt <= gap_cnt - 32'h1;
            end
            S_REV: begin
               gap_cnt <= prm[11];
               if (remain == 32'h0)
                  st <= S_GAP2;
            end
            S_GAP2: begin
               if (gap_cnt == 32'h0) begin
                  rep_cnt <= rep_cnt + 32'h1;
                  st <= (rep_cnt + 32'h1 >= prm[12]) ? S_IDLE : S_FWD;
               end else if (ms_tick) begin
                  gap_cnt <= gap_cnt - 32'h1;
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end
end
// ---------------------------------------------------------------
// trace
// ---------------------------------------------------------------
reg [31:0] tmem [0:`SVPL_TR_DEPTH-1];
reg tr_on;
reg [6:0] tr_wp;
reg [31:0] tr_ms;
reg signed [31:0] cmd_ms, enc_ms, v_ref, v_fb;
reg [31:0] tr_smp;
always @* begin
   case (prm[14][3:0])
      4'h0: tr_smp = torque_set - i_meas;
      4'h1: tr_smp = v_ref - v_fb;
      4'h2: tr_smp = perr;
      4'h3: tr_smp = i_meas;
      4'h4: tr_smp = v_fb;
      4'h5: tr_smp = enc_pos;
      4'h6: tr_smp = torque_set;
      4'h7: tr_smp = v_ref;
      default: tr_smp = cmd_pos;
   endcase
end
always @(posedge pclk) begin
   if (tr_on && ms_tick && tr_wp != `SVPL_TR_DEPTH)
      tmem[tr_wp[5:0]] <= tr_smp;
end
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      tr_on <= 1'b0;
      tr_wp <= 7'h0;
      tr_ms <= 32'h0;
      cmd_ms <= 32'sh0;
      enc_ms <= 32'sh0;
      v_ref <= 32'sh0;
      v_fb <= 32'sh0;
      tr_idx <= 6'h0;
   end else begin
      if (apb_wr && paddr == `SVPL_A_TRIDX)
         tr_idx <= pwdata[5:0];
      if (ms_tick) begin
         cmd_ms <= cmd_pos;
         enc_ms <= enc_pos;
         v_ref <= cmd_pos - cmd_ms;
         v_fb <= enc_pos - enc_ms;
      end
      if (trace_go) begin
         tr_on <= 1'b1;
         tr_wp <= 7'h0;
         tr_ms <= 32'h0;
      end else if (tr_on && ms_tick) begin
         tr_wp <= (tr_wp == `SVPL_TR_DEPTH) ? tr_wp : tr_wp + 7'h1;
         tr_ms <= tr_ms + 32'h1;
         if (tr_ms + 32'h1 >= prm[13])
            tr_on <= 1'b0;
      end
   end
end
// ---------------------------------------------------------------
// serial link and parameter storage
// ---------------------------------------------------------------
reg [8:0] rx_cnt, tx_cnt;
reg [3:0] rx_bit, tx_bits;
reg rx_busy;
reg [7:0] rx_sh;
reg [9:0] tx_sh;
reg up_on, sv_on;
reg [5:0] up_idx;
reg [3:0] sv_idx;
wire [31:0] baud_n = `SVPL_BAUD_DIV - 1;
wire [31:0] up_word = prm[up_idx[5:2]];
wire [7:0] up_byte = up_word[{up_idx[1:0], 3'h0} +: 8];
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      rx_cnt <= 9'h0;
      rx_bit <= 4'h0;
      rx_busy <= 1'b0;
      rx_sh <= 8'h0;
      rx_done <= 1'b0;
      rx_byte <= 8'h0;
      tx_cnt <= 9'h0;
      tx_bits <= 4'h0;
      tx_sh <= 10'h3ff;
      uart_txd <= 1'b1;
      up_on <= 1'b0;
      up_idx <= 6'h0;
      sv_on <= 1'b0;
      sv_idx <= 4'h0;
      nv_wr <= 1'b0;
      nv_addr <= 4'h0;
      nv_data <= 32'h0;
   end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
         if (!uart_rxd) begin
            rx_busy <= 1'b1;
            rx_bit <= 4'h0;
            rx_cnt <= baud_n[9:1];
         end
      end else if (rx_cnt != 9'h0) begin
         rx_cnt <= rx_cnt - 9'h1;
      end else begin
         rx_cnt <= baud_n[8:0];
         rx_bit <= rx_bit + 4'h1;
         if (rx_bit == 4'h0 && uart_rxd)
            rx_busy <= 1'b0;
         else if (rx_bit != 4'h0 && rx_bit != 4'h9)
            rx_sh <= {uart_rxd, rx_sh[7:1]};
         else if (rx_bit == 4'h9) begin
            rx_busy <= 1'b0;
            rx_done <= uart_rxd;
            rx_byte <= rx_sh;
         end
      end
      if (rx_cmd_r && !up_on) begin
         up_on <= 1'b1;
         up_idx <= 6'h0;
      end
      if (tx_bits != 4'h0) begin
         if (tx_cnt != 9'h0) begin
            tx_cnt <= tx_cnt - 9'h1;
         end else begin
            tx_cnt <= baud_n[8:0];
            uart_txd <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_bits <= tx_bits - 4'h1;
         end
      end else if (up_on) begin
         tx_sh <= {1'b1, up_byte, 1'b0};
         tx_bits <= 4'hb;
         tx_cnt <= 9'h0;
         up_idx <= up_idx + 6'h1;
         if (up_idx == `SVPL_NPAR * 4 - 1)
            up_on <= 1'b0;
      end
      nv_wr <= sv_on;
      nv_addr <= sv_idx;
      nv_data <= prm[sv_idx];
      if (save_go && !sv_on) begin
         sv_on <= 1'b1;
         sv_idx <= 4'h0;
      end else if (sv_on) begin
         if (sv_idx == `SVPL_NPAR - 1)
            sv_on <= 1'b0;
         else
            sv_idx <= sv_idx + 4'h1;
      end
   end
end
// ---------------------------------------------------------------
// apb read and answer
// ---------------------------------------------------------------
always @* begin
   if (is_par(paddr))
      rd_mux = prm[paddr[5:2]];
   else if (paddr == `SVPL_A_STATUS)
      rd_mux = {17'h0, tr_wp, tr_on, up_on, sv_on, st != S_IDLE, st[1], fe_protect, 2'h0};
   else if (paddr == `SVPL_A_CMDPOS)
      rd_mux = cmd_pos;
   else if (paddr == `SVPL_A_ENCPOS)
      rd_mux = enc_pos;
   else if (paddr == `SVPL_A_PERR)
      rd_mux = perr;
   else if (paddr == `SVPL_A_TORQUE)
      rd_mux = torque_set;
   else if (paddr == `SVPL_A_TRIDX)
      rd_mux = {26'h0, tr_idx};
   else if (paddr == `SVPL_A_TRDATA)
      rd_mux = tmem[tr_idx];
   else
      rd_mux = 32'h0;
end
wire addr_ok = is_par(paddr) || (paddr[1:0] == 2'h0 && paddr >= `SVPL_A_STATUS
   && paddr <= `SVPL_A_TRDATA);
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
   end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
         prdata <= rd_mux;
         pslverr <= ~addr_ok;
      end
   end
end
endmodule // svpl_top
`default_nettype wire

// ==== svpl_props.sv ====
/* svpl_props.sv: port checker for svpl_top.
 Assumes one pclk domain with active-low asynchronous presetn. */
`include "svpl_map.vh"
`default_nettype none
module svpl_props (
   // watched ports
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic signed [31:0] torque_set,
   input wire logic fe_protect,
   input wire logic uart_txd,
   input wire logic nv_wr,
   input wire logic [3:0] nv_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire ctl = psel && penable && pwrite && paddr == 8'h00;
   property p_ready;
      $past(presetn) |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_rd_hold;
      !psel |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
   property p_fe_sticky;
      fe_protect && !(ctl && pwdata[`SVPL_B_CLRFE]) |=> fe_protect;
   endproperty
   a_fe_sticky: assert property (p_fe_sticky) else $error("trip lost");
   property p_fe_zero;
      fe_protect && $past(fe_protect) |-> torque_set == 32'sh0;
   endproperty
   a_fe_zero: assert property (p_fe_zero) else $error("torque while tripped");
   property p_tq_hold;
      $changed(torque_set) |=> $stable(torque_set) [*8];
   endproperty
   a_tq_hold: assert property (p_tq_hold) else $error("torque too fast");
   property p_nv_go;
      ctl && pwdata[`SVPL_B_SAVE] |-> ##[1:3] (nv_wr && nv_addr == 4'h0);
   endproperty
   a_nv_go: assert property (p_nv_go) else $error("save not started");
   property p_nv_seq;
      nv_wr && nv_addr != 4'he |=> nv_wr && nv_addr == $past(nv_addr) + 4'h1;
   endproperty
   a_nv_seq: assert property (p_nv_seq) else $error("save gap");
   property p_txd_bit;
      $fell(uart_txd) |-> ##259 !uart_txd;
   endproperty
   a_txd_bit: assert property (p_txd_bit) else $error("short bit");
endmodule // svpl_props
bind svpl_top svpl_props i_svpl_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .torque_set(torque_set), .fe_protect(fe_protect),
   .uart_txd(uart_txd), .nv_wr(nv_wr), .nv_addr(nv_addr));
`default_nettype wire

// ==== svpl_host.sv ====
/* svpl_host.sv: step/direction source, quadrature encoder, serial host.
 Assumes pclk at 10 MHz; all pins change just after a rising edge. */
`default_nettype none
module svpl_host (
   // clock
   input wire logic pclk,
   // far-side pins
   output logic step_in = 1'b0,
   output logic dir_in = 1'b0,
   output logic enc_a = 1'b0,
   output logic enc_b = 1'b0,
   output logic uart_rxd = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph = 2'h0;
   // n level changes on one command pin
   task automatic toggle(input bit pin, input int n, input int gap);
      repeat (n) begin
         @(posedge pclk);
         if (pin) dir_in <= ~dir_in;
         else step_in <= ~step_in;
         repeat (gap) @(posedge pclk);
      end
   endtask
   // gray walk, up is 00-10-11-01
   task automatic enc_move(input int n, input bit up);
      repeat (n) begin
         @(posedge pclk);
         ph = up ? ph + 2'h1 : ph - 2'h1;
         enc_a <= ph[1] ^ ph[0];
         enc_b <= ph[1];
         repeat (3) @(posedge pclk);
      end
   endtask
   // 8N1 byte, 260 clocks a bit, idles high
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge pclk);
         uart_rxd <= f[i];
         repeat (259) @(posedge pclk);
      end
   endtask
endmodule // svpl_host
`default_nettype wire

// ==== servo_position_loop_test.sv ====
/* servo_position_loop_test.sv: self-checking bench for svpl_top.
 Assumes svpl_host on the far side and the bound checker. */
`include "svpl_map.vh"
`default_nettype none
`define SVPL_CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module servo_position_loop_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q, nv_data;
   logic signed [31:0] i_meas = 32'sh0, torque_set;
   logic pready, pslverr, fe_protect, uart_txd, nv_wr, step_in, dir_in, enc_a, enc_b, uart_rxd;
   logic [3:0] nv_addr;
   int n_mismatch = 0, compares = 0, exp_cmd = 0, exp_enc = 0, e, k, t, top, bot;
   logic [31:0] rst_val [15] = '{32'h0, 32'h1, 32'h1, 32'h100, 32'h0, 32'h40, 32'h1000,
      32'h1f4, 32'h64, 32'ha, 32'hfa0, 32'h64, 32'h1, 32'h40, 32'h0};
   always #50 pclk = ~pclk;
   svpl_top i_svpl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_in(step_in), .dir_in(dir_in), .enc_a(enc_a), .enc_b(enc_b),
      .i_meas(i_meas), .torque_set(torque_set), .fe_protect(fe_protect),
      .uart_rxd(uart_rxd), .uart_txd(uart_txd), .nv_wr(nv_wr), .nv_addr(nv_addr),
      .nv_data(nv_data));
   svpl_host i_svpl_host (.pclk(pclk), .step_in(step_in), .dir_in(dir_in), .enc_a(enc_a),
      .enc_b(enc_b), .uart_rxd(uart_rxd));
   task automatic tally_and_finish();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one apb transfer, read data left in q
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         tally_and_finish();
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      `SVPL_CHK(nm, ex, q)
   endtask
   // n changes of one pin, counted on the chosen edge at 1:1 gear
   task automatic steps(input bit pin, input int n, input int sgn, input bit fall);
      int r;
      r = (n + !(pin ? dir_in : step_in)) / 2;
      i_svpl_host.toggle(pin, n, 260);
      exp_cmd += sgn * (fall ? n - r : r);
   endtask
   initial begin
      void'($urandom(81763));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 15; i++) rdc("param", 8'(4 * i), rst_val[i]);
      apb(1'b0, 8'hfc, 32'h0);
      `SVPL_CHK("unmapped", 1'b1, pslverr)
      wr(8'h04, 32'h0);
      rdc("gear zero", 8'h04, 32'h1);
      wr(8'h04, 32'h1ff);
      rdc("gear wide", 8'h04, 32'hff);
      wr(8'h04, 32'h1);
      for (int m = 0; m < 8; m++) begin
         i_svpl_host.dir_in <= m[2];
         wr(8'h00, {29'h0, m[1], 1'b0, m[0]});
         steps(1'b0, 3, (m[2] ^ m[1]) ? 1 : -1, m[0]);
         rdc("cmd pos", 8'h44, exp_cmd);
      end
      wr(8'h00, 32'h2);
      for (int m = 0; m < 4; m++) steps(m[0], 3, m[0] ? -1 : 1, 1'b0);
      rdc("cw ccw pos", 8'h44, exp_cmd);
      i_svpl_host.enc_move(5, 1'b1);
      i_svpl_host.enc_move(2, 1'b0);
      wr(8'h1c, 32'h7d0);
      i_svpl_host.enc_move(4, 1'b1);
      exp_enc = 7;
      rdc("enc pos", 8'h48, exp_enc);
      rdc("pos error", 8'h4c, exp_cmd - exp_enc);
      wr(8'h00, 32'h0);
      top = 1 + $urandom % 255;
      bot = 1 + $urandom % 255;
      k = 1 + $urandom % 8;
      wr(8'h04, top);
      wr(8'h08, bot);
      i_svpl_host.dir_in <= 1'b1;
      i_svpl_host.toggle(1'b0, 2 * k - !step_in, 260);
      exp_cmd += k * top / bot;
      rdc("geared pos", 8'h44, exp_cmd);
      e = exp_cmd - exp_enc;
      wr(8'h14, 32'h0);
      wr(8'h0c, 32'h200);
      repeat (2100) @(posedge pclk);
      `SVPL_CHK("p term", 2 * e, torque_set)
      wr(8'h10, 32'h100);
      repeat (1100) @(posedge pclk);
      t = torque_set;
      repeat (1000) @(posedge pclk);
      `SVPL_CHK("i term", t + e, torque_set)
      wr(8'h0c, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h300);
      repeat (2100) @(posedge pclk);
      `SVPL_CHK("d steady", 0, torque_set)
      i_svpl_host.enc_move(1, 1'b1);
      exp_enc += 1;
      t = 0;
      repeat (1100) begin
         @(posedge pclk);
         if (torque_set < t) t = torque_set;
      end
      `SVPL_CHK("d kick", -3, t)
      e = exp_cmd - exp_enc;
      wr(8'h18, (e < 0 ? -e : e) + 1);
      `SVPL_CHK("fe below", 1'b0, fe_protect)
      i_svpl_host.enc_move(1, e < 0);
      wr(8'h00, 32'h20);
      `SVPL_CHK("fe held", 1'b1, fe_protect)
      i_svpl_host.enc_move(1, e >= 0);
      wr(8'h00, 32'h20);
      @(posedge pclk);
      `SVPL_CHK("fe cleared", 1'b0, fe_protect)
      wr(8'h00, 32'h10);
      t = 0;
      repeat (40) begin
         @(posedge pclk);
         if (nv_wr === 1'b1) t++;
         if (nv_wr === 1'b1 && nv_addr === 4'h2) `SVPL_CHK("saved bottom", bot, nv_data)
      end
      `SVPL_CHK("saved words", 15, t)
      wr(8'h00, 32'h8);
      rdc("busy", 8'h40, 32'h18);
      wr(8'h00, 32'h8);
      rdc("stopped", 8'h40, 32'h0);
      wr(8'h34, 1);
      wr(8'h38, 2);
      wr(8'h00, 32'h40);
      i_svpl_host.send_byte(`SVPL_C_TOGGLE);
      repeat (10300) @(posedge pclk);
      rdc("serial start", 8'h40, 32'h118);
      rdc("trace p", 8'h58, exp_cmd - exp_enc);
      wr(8'h00, 32'h8);
      i_svpl_host.send_byte(`SVPL_C_READ);
      rdc("upload", 8'h40, 32'h140);
      repeat (5000) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `SVPL_CHK("txd idle", 1'b1, uart_txd)
      tally_and_finish();
   end
endmodule // servo_position_loop_test
`default_nettype wire
